// ==== bench/host_cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Host side: keeps the shared restart and init flag words.
module host_cpu_model
    import mode_ctl_pkg::*;
(
    input wire logic clk,
    input wire logic [mode_ctl_pkg::UNIT_W-1:0] unit,
    input wire logic init_busy,
    output logic restart_flag,
    output logic init_flag
);
    // One bit per unit, sixteen units to a word, units 0 to 95.
    logic [15:0] restart_words [6] = '{default: 16'h0000};
    logic [15:0] init_words [6] = '{default: 16'hFFFF};
    assign restart_flag = restart_words[unit / 16][unit % 16];
    assign init_flag = init_words[unit / 16][unit % 16];
    // The init word copies the unit's flag every cycle.
    always @(posedge clk) init_words[unit / 16][unit % 16] <= init_busy;
    // Set the unit's restart bit, hold it, then clear it.
    task automatic restart();
        @(negedge clk);
        restart_words[unit / 16][unit % 16] = 1'b1;
        repeat (4) @(negedge clk);
        restart_words[unit / 16][unit % 16] = 1'b0;
    endtask : restart
    // Give no command until the init flag reads low.
    task automatic wait_ready(output bit ok);
        ok = 0;
        for (int i = 0; i < 200 && !ok; i++) begin
            @(negedge clk);
            ok = (init_flag === 1'b0);
        end
        @(negedge clk);
    endtask : wait_ready
endmodule : host_cpu_model
`default_nettype wire

// ==== bench/unit_restart_mode_control_props.sv ====
`timescale 1ns/1ps
`default_nettype none
// Watches the init flag, mode bits and action pulses at the top ports.
module unit_restart_mode_control_props
    import mode_ctl_pkg::*;
#(
    parameter int INIT_LEN = 8
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [mode_ctl_pkg::UNIT_W-1:0] UNIT_NUMBER,
    input wire logic [mode_ctl_pkg::ADDR_W-1:0] HOST_RD_ADDR,
    input wire logic [mode_ctl_pkg::WORD_W-1:0] HOST_RD_DATA,
    input wire logic INIT_BUSY,
    input wire logic [mode_ctl_pkg::NUM_TASKS-1:0] AUTO_MODE,
    input wire logic [mode_ctl_pkg::NUM_TASKS-1:0] RUN_PROGRAM,
    input wire mode_ctl_pkg::task_act_t [mode_ctl_pkg::NUM_TASKS-1:0] TASK_ACT,
    input wire logic [10:0] AXIS_CMD_EN,
    input wire logic SAVE_START
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    // Counts the cycles the init flag has stood high in a row.
    int busy_cnt_q;
    // Base word of this unit, used to spot an unmapped read.
    logic [ADDR_W-1:0] base;
    assign base = AREA_BASE + AREA_STRIDE * ADDR_W'(UNIT_NUMBER);
    // Clears whenever the flag is low, so a short busy phase shows.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            busy_cnt_q <= 0;
        end else begin
            busy_cnt_q <= INIT_BUSY ? busy_cnt_q + 1 : 0;
        end
    end
    chk_busy_long_enough: assert property ($fell(INIT_BUSY) |-> busy_cnt_q >= INIT_LEN)
        else $error("init flag dropped too early");
    chk_busy_no_action: assert property (INIT_BUSY |-> TASK_ACT == '0 && !SAVE_START)
        else $error("action while initialising");
    chk_run_follows_auto: assert property (!INIT_BUSY |-> RUN_PROGRAM == AUTO_MODE)
        else $error("program run does not follow mode");
    chk_rise_manual_stop: assert property ($rose(AUTO_MODE[0]) |-> TASK_ACT[0] == 3'b100)
        else $error("rising mode bit without manual stop");
    chk_fall_halt_all: assert property ($fell(AUTO_MODE[0]) && !INIT_BUSY |-> TASK_ACT[0] == 3'b011)
        else $error("falling mode bit without halt");
    chk_task_own_pulse: assert property (TASK_ACT[1].manual_stop |-> $rose(AUTO_MODE[1]))
        else $error("task pulse without its own mode change");
    chk_save_one_cycle: assert property (SAVE_START |=> !SAVE_START)
        else $error("save start longer than one cycle");
    chk_auto_cmd_mask: assert property (|AUTO_MODE |-> (AXIS_CMD_EN & 11'h3EF) == 11'h000)
        else $error("manual command passed in automatic mode");
    chk_unmapped_read: assert property ($past(HOST_RD_ADDR) == base + 12'h004 |-> HOST_RD_DATA == '0)
        else $error("unmapped word reads non-zero");
endmodule : unit_restart_mode_control_props
`default_nettype wire

// ==== bench/unit_restart_mode_control_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; $display("Error at %0t: got %h want %h", $time, a, b); end end
// Drives host writes and command bits, compares with a bench model.
module unit_restart_mode_control_tb_top;
    import mode_ctl_pkg::*;
    logic clk = 0;
    logic rst = 1;
    logic restart_flag;
    logic init_flag;
    logic save_req = 0;
    logic [10:0] cmd_bits = '0;
    logic [10:0] cmd_en;
    host_wr_t host_wr = '0;
    logic [ADDR_W-1:0] rd_addr = '0;
    logic [WORD_W-1:0] rd_data;
    logic init_busy;
    logic save_start;
    logic [3:0] auto_mode;
    logic [3:0] run_prog;
    task_act_t [3:0] act;
    logic [3:0] mdl_auto = '0; // Bench model of the four mode bits.
    logic [31:0] seed = 32'hB17B270A;
    logic [3:0] ofs_t [4] = '{TASK1_MODE_OFS, TASK2_MODE_OFS, TASK3_MODE_OFS, TASK4_MODE_OFS};
    localparam logic [ADDR_W-1:0] BASE = 12'h7EE; // Unit 3: 2000 + 30.
    int err_count = 0;
    int total_checks = 0;
    bit ok;
    logic seen; // Gathers a one-cycle pulse over a few cycles.
    initial forever #10 clk = ~clk;
    unit_restart_mode_control #(.INIT_LEN(8)) dut (.CLK(clk), .RST(rst), .UNIT_NUMBER(7'h03),
        .RESTART_FLAG(restart_flag), .HOST_WR(host_wr), .HOST_RD_ADDR(rd_addr),
        .SAVE_REQ(save_req), .AXIS_CMD_BITS(cmd_bits), .HOST_RD_DATA(rd_data),
        .INIT_BUSY(init_busy), .AUTO_MODE(auto_mode), .RUN_PROGRAM(run_prog),
        .TASK_ACT(act), .AXIS_CMD_EN(cmd_en), .SAVE_START(save_start));
    host_cpu_model host (.clk(clk), .unit(7'h03), .init_busy(init_busy),
        .restart_flag(restart_flag), .init_flag(init_flag));
    // One host word write, valid for one cycle.
    task automatic wr(input logic [3:0] ofs, input logic [15:0] d);
        @(negedge clk);
        host_wr <= '{valid: 1'b1, addr: BASE + 12'(ofs), data: d};
        @(negedge clk);
        host_wr.valid <= 1'b0;
    endtask : wr
    // Write a task word, check the pulses, the modes and the read back.
    task automatic do_task(input int t, input logic [15:0] d);
        logic old;
        old = mdl_auto[t];
        mdl_auto[t] = d[1];
        wr(ofs_t[t], d);
        rd_addr <= BASE + 12'(ofs_t[t]);
        // The action pulse stands for one cycle only, so look one cycle later.
        @(negedge clk);
        `CHK(act[t], {!old && d[1], old && !d[1], old && !d[1]})
        `CHK(auto_mode, mdl_auto)
        `CHK(run_prog, mdl_auto)
        `CHK(rd_data[1], d[1])
    endtask : do_task
    // A one-cycle command pulse; gather what the design lets through.
    task automatic pulse_cmd(input logic [10:0] bits, input logic [10:0] exp);
        logic [10:0] acc;
        acc = '0;
        cmd_bits <= bits;
        @(negedge clk);
        cmd_bits <= '0;
        repeat (6) begin
            @(negedge clk);
            acc |= cmd_en;
        end
        `CHK(acc, exp)
    endtask : pulse_cmd
    // Steps the bench's random source by one shift.
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    task automatic results();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results
    // The tests need a few hundred cycles; this leaves a wide margin.
    localparam int TIMEOUT_CYCLES = 2000;
    initial begin
        repeat (TIMEOUT_CYCLES) @(posedge clk);
        err_count++;
        results();
    end
    initial begin
        repeat (20) @(negedge clk);
        rst <= 0;
        `CHK(init_busy, 1'b1)
        wr(ofs_t[0], 16'h0002);
        host.wait_ready(ok);
        `CHK(ok, 1'b1)
        `CHK(auto_mode, 4'h0)
        $display("test init done");
        for (int t = 0; t < 4; t++) begin
            do_task(t, 16'h0002);
            do_task(t, 16'h0000);
        end
        for (int i = 0; i < 8; i++) begin
            seed = lfsr_next(seed);
            do_task(seed[17:16], seed[15:0]);
        end
        wr(4'h4, 16'hFFFF);
        rd_addr <= BASE + 12'h004;
        repeat (2) @(negedge clk);
        `CHK(auto_mode, mdl_auto)
        `CHK(rd_data, 16'h0000)
        $display("test modes done");
        for (int k = 0; k < 4; k++) do_task(k, 16'h0000);
        for (int k = 0; k < 11; k++) pulse_cmd(11'h001 << k, 11'h001 << k);
        do_task(1, 16'h0002);
        pulse_cmd(11'h7FF, 11'h410);
        save_req <= 1'b1;
        seen = 1'b0;
        repeat (4) begin
            @(negedge clk);
            seen |= save_start;
        end
        `CHK(seen, 1'b1)
        `CHK(save_start, 1'b0)
        save_req <= 1'b0;
        $display("test commands done");
        host.restart();
        repeat (4) @(negedge clk);
        `CHK(init_busy, 1'b1)
        host.wait_ready(ok);
        `CHK(ok, 1'b1)
        `CHK(auto_mode, 4'h0)
        $display("test restart done");
        results();
    end
endmodule : unit_restart_mode_control_tb_top
bind unit_restart_mode_control unit_restart_mode_control_props #(.INIT_LEN(INIT_LEN)) props_i (
    .CLK(CLK), .RST(RST), .UNIT_NUMBER(UNIT_NUMBER), .HOST_RD_ADDR(HOST_RD_ADDR),
    .HOST_RD_DATA(HOST_RD_DATA), .INIT_BUSY(INIT_BUSY), .AUTO_MODE(AUTO_MODE),
    .RUN_PROGRAM(RUN_PROGRAM), .TASK_ACT(TASK_ACT), .AXIS_CMD_EN(AXIS_CMD_EN),
    .SAVE_START(SAVE_START));
`default_nettype wire

// ==== core/bit_edge_detect.sv ====
`timescale 1ns/1ps
`default_nettype none
// Compares each sampled bit with its previous sample and pulses on each change.
module bit_edge_detect #(
    parameter int WIDTH = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);
    // Previous sample of the level.
    logic [WIDTH-1:0] prev_q;
    logic [WIDTH-1:0] prev_d;

    // Next previous-sample value follows the level; clear forces zero.
    always_comb begin
        prev_d = clear ? '0 : level;
    end

    // Register the sample.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_q <= '0;
        end else begin
            prev_q <= prev_d;
        end
    end

    // One-cycle pulses for each transition, masked while cleared.
    assign rise = clear ? '0 : (level & ~prev_q);
    assign fall = clear ? '0 : (~level & prev_q);
endmodule : bit_edge_detect
`default_nettype wire

// ==== core/mode_ctl_pkg.sv ====
package mode_ctl_pkg;

    // Word offsets of the task mode control words relative to base n.
    localparam logic [3:0] TASK1_MODE_OFS = 4'h3;
    localparam logic [3:0] TASK2_MODE_OFS = 4'h5;
    localparam logic [3:0] TASK3_MODE_OFS = 4'h7;
    localparam logic [3:0] TASK4_MODE_OFS = 4'h9;

    // Bit position of the automatic/manual bit in a task word.
    localparam int MODE_BIT = 1;

    // Word layout of the interface area.
    localparam int WORD_W = 16;
    localparam int NUM_TASKS = 4;
    localparam int UNIT_W = 7;
    localparam int ADDR_W = 12;

    // Base word is 2000 plus ten times the unit number.
    localparam logic [ADDR_W-1:0] AREA_BASE = 12'h7D0;
    localparam logic [ADDR_W-1:0] AREA_STRIDE = 12'h00A;

    // Reset value of the task words (manual mode).
    localparam logic [WORD_W-1:0] TASK_WORD_RST = 16'h0000;

    // Length of initial processing, in nanoseconds, and the clock period.
    localparam int INIT_TIME_NS = 100000;
    localparam int CLK_PERIOD_NS = 20;
    localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Host write request carried as one bundle.
    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] data;
    } host_wr_t;

    // Per-task action pulses toward the motion core.
    typedef struct packed {
        logic manual_stop;
        logic program_halt;
        logic all_axes_stop;
    } task_act_t;

endpackage : mode_ctl_pkg

// ==== core/unit_restart_mode_control.sv ====
`timescale 1ns/1ps
`default_nettype none
module unit_restart_mode_control
    import mode_ctl_pkg::*;
#(
    parameter int NUM_TASKS_USED = mode_ctl_pkg::NUM_TASKS,
    parameter int INIT_LEN = mode_ctl_pkg::INIT_CYCLES
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [mode_ctl_pkg::UNIT_W-1:0] UNIT_NUMBER,
    input wire logic RESTART_FLAG,
    input wire mode_ctl_pkg::host_wr_t HOST_WR,
    input wire logic [mode_ctl_pkg::ADDR_W-1:0] HOST_RD_ADDR,
    input wire logic SAVE_REQ,
    input wire logic [10:0] AXIS_CMD_BITS,
    output logic [mode_ctl_pkg::WORD_W-1:0] HOST_RD_DATA,
    output logic INIT_BUSY,
    output logic [mode_ctl_pkg::NUM_TASKS-1:0] AUTO_MODE,
    output logic [mode_ctl_pkg::NUM_TASKS-1:0] RUN_PROGRAM,
    output mode_ctl_pkg::task_act_t [mode_ctl_pkg::NUM_TASKS-1:0] TASK_ACT,
    output logic [10:0] AXIS_CMD_EN,
    output logic SAVE_START
);
    import mode_ctl_pkg::*;

    // Width of the initial processing counter.
    localparam int CNT_W = $clog2(INIT_LEN + 1);
    // Command bit positions of the error counter reset and servo unlock.
    localparam int CMD_ERR_RST = 4;
    localparam int CMD_SERVO_UNLOCK = 10;
    // Only these two commands pass while any task is automatic.
    localparam logic [10:0] AUTO_CMD_MASK = (11'h001 << CMD_ERR_RST)
                                            | (11'h001 << CMD_SERVO_UNLOCK);

    // Sequencer states.
    typedef enum logic [1:0] {
        ST_INIT,
        ST_RUN,
        ST_RESTART_HELD
    } seq_state_t;

    // Returns the word address of a task offset for the configured unit.
    function automatic logic [ADDR_W-1:0] word_addr(input logic [UNIT_W-1:0] unit,
                                                     input logic [3:0] ofs);
        logic [ADDR_W-1:0] prod;
        prod = 12'(AREA_STRIDE * {{(ADDR_W-UNIT_W){1'b0}}, unit});
        word_addr = AREA_BASE + prod + {{(ADDR_W-4){1'b0}}, ofs};
    endfunction : word_addr

    // Returns the offset belonging to a task index.
    function automatic logic [3:0] task_ofs(input int idx);
        unique case (idx)
            0: task_ofs = TASK1_MODE_OFS;
            1: task_ofs = TASK2_MODE_OFS;
            2: task_ofs = TASK3_MODE_OFS;
            default: task_ofs = TASK4_MODE_OFS;
        endcase
    endfunction : task_ofs

    // Two-flop synchronisers for the pin inputs from the host.
    logic restart_s1_q;
    logic restart_s2_q;
    logic save_s1_q;
    logic save_s2_q;
    logic [10:0] cmd_s1_q;
    logic [10:0] cmd_s2_q;

    // Synchroniser chains; the first stage feeds only the second.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            restart_s1_q <= 1'b0;
            restart_s2_q <= 1'b0;
            save_s1_q <= 1'b0;
            save_s2_q <= 1'b0;
            cmd_s1_q <= '0;
            cmd_s2_q <= '0;
        end else begin
            restart_s1_q <= RESTART_FLAG;
            restart_s2_q <= restart_s1_q;
            save_s1_q <= SAVE_REQ;
            save_s2_q <= save_s1_q;
            cmd_s1_q <= AXIS_CMD_BITS;
            cmd_s2_q <= cmd_s1_q;
        end
    end

    // Sequencer registers.
    seq_state_t state_q;
    seq_state_t state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic restart_prev_q;
    logic restart_prev_d;
    logic save_prev_q;
    logic save_prev_d;
    logic busy;

    // Initial processing runs after reset and after a restart request is released.
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        restart_prev_d = restart_s2_q;
        save_prev_d = save_s2_q;
        unique case (state_q)
            ST_INIT: begin
                // Count out initial processing, applies on every entry.
                if (restart_s2_q) begin
                    state_d = ST_RESTART_HELD;
                end else if (cnt_q == CNT_W'(INIT_LEN - 1)) begin
                    state_d = ST_RUN;
                end else begin
                    cnt_d = cnt_q + CNT_W'(1);
                end
            end
            ST_RUN: begin
                // A set restart flag holds the unit until it is cleared.
                if (restart_s2_q) begin
                    state_d = ST_RESTART_HELD;
                end
            end
            ST_RESTART_HELD: begin
                // Clearing the flag starts a full restart like power-up.
                if (!restart_s2_q && restart_prev_q) begin
                    state_d = ST_INIT;
                    cnt_d = '0;
                end
            end
            default: begin
                state_d = ST_INIT;
                cnt_d = '0;
            end
        endcase
    end

    // Register the sequencer.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_q <= ST_INIT;
            cnt_q <= '0;
            restart_prev_q <= 1'b0;
            save_prev_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            restart_prev_q <= restart_prev_d;
            save_prev_q <= save_prev_d;
        end
    end

    // The unit is busy whenever it is not running normally.
    assign busy = (state_q != ST_RUN);

    // Task mode words, volatile, reset to manual mode.
    logic [NUM_TASKS-1:0][WORD_W-1:0] task_word_q;
    logic [NUM_TASKS-1:0][WORD_W-1:0] task_word_d;
    logic [NUM_TASKS-1:0] mode_lvl;

    // Host writes update only the addressed task word, never while busy.
    always_comb begin
        task_word_d = task_word_q;
        for (int t = 0; t < NUM_TASKS; t++) begin
            if (busy) begin
                // Working memory is lost on restart; writes are dropped.
                task_word_d[t] = TASK_WORD_RST;
            end else if (t < NUM_TASKS_USED && HOST_WR.valid
                         && HOST_WR.addr == word_addr(UNIT_NUMBER, task_ofs(t))) begin
                task_word_d[t] = HOST_WR.data;
            end
        end
    end

    // Register the task words.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            task_word_q <= '0;
        end else begin
            task_word_q <= task_word_d;
        end
    end

    // Mode bit of each task: one is automatic, zero is manual.
    always_comb begin
        for (int t = 0; t < NUM_TASKS; t++) begin
            mode_lvl[t] = task_word_q[t][MODE_BIT];
        end
    end

    // Edge detection of the mode bits inside the device.
    logic [NUM_TASKS-1:0] mode_rise;
    logic [NUM_TASKS-1:0] mode_fall;
    logic [10:0] cmd_rise;

    bit_edge_detect #(.WIDTH(NUM_TASKS)) u_mode_edges (
        .clk(CLK),
        .rst(RST),
        .clear(busy),
        .level(mode_lvl),
        .rise(mode_rise),
        .fall(mode_fall)
    );

    // Edge detection of the axis command bits.
    bit_edge_detect #(.WIDTH(11)) u_cmd_edges (
        .clk(CLK),
        .rst(RST),
        .clear(busy),
        .level(cmd_s2_q),
        .rise(cmd_rise),
        .fall()
    );

    // Output registers.
    logic [WORD_W-1:0] rd_data_d;
    logic [WORD_W-1:0] rd_data_q;
    task_act_t [NUM_TASKS-1:0] act_d;
    task_act_t [NUM_TASKS-1:0] act_q;
    logic [10:0] cmd_en_d;
    logic [10:0] cmd_en_q;
    logic save_d;
    logic save_q;
    logic any_auto;

    // Computes action pulses, command enables, save start and read data.
    always_comb begin
        rd_data_d = '0;
        any_auto = |mode_lvl;
        for (int t = 0; t < NUM_TASKS; t++) begin
            act_d[t].manual_stop = mode_rise[t];
            act_d[t].program_halt = mode_fall[t];
            act_d[t].all_axes_stop = mode_fall[t];
            if (!busy && t < NUM_TASKS_USED
                && HOST_RD_ADDR == word_addr(UNIT_NUMBER, task_ofs(t))) begin
                rd_data_d = task_word_q[t];
            end
        end
        // Manual commands pass in manual mode; two also in automatic.
        cmd_en_d = any_auto ? (cmd_rise & AUTO_CMD_MASK) : cmd_rise;
        save_d = !busy && save_s2_q && !save_prev_q;
    end

    // Register the read data, action pulse, command enable and save start outputs.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rd_data_q <= '0;
            act_q <= '0;
            cmd_en_q <= '0;
            save_q <= 1'b0;
        end else begin
            rd_data_q <= rd_data_d;
            act_q <= act_d;
            cmd_en_q <= cmd_en_d;
            save_q <= save_d;
        end
    end

    // Busy flag and mode levels registered for the outputs.
    logic busy_q;
    logic [NUM_TASKS-1:0] auto_q;
    logic [NUM_TASKS-1:0] run_q;

    // Program run level follows automatic mode while the unit is not busy; it is zero while busy.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            busy_q <= 1'b1;
            auto_q <= '0;
            run_q <= '0;
        end else begin
            busy_q <= busy;
            auto_q <= mode_lvl;
            run_q <= busy ? '0 : mode_lvl;
        end
    end

    assign HOST_RD_DATA = rd_data_q;
    assign INIT_BUSY = busy_q;
    assign AUTO_MODE = auto_q;
    assign RUN_PROGRAM = run_q;
    assign TASK_ACT = act_q;
    assign AXIS_CMD_EN = cmd_en_q;
    assign SAVE_START = save_q;
endmodule : unit_restart_mode_control
`default_nettype wire
